// *** core/adcr_pkg.sv ***
// Overview of operation
// - bits 6-4 of the output stage register pick the switching rate 768, 384, 480 or 576 kHz, other codes reserved.
// - bit 2 of the output stage register picks bridge-tied load at zero and paralleled bridge at one, resetting to zero.
// - bits 1-0 of the output stage register pick BD, single-sided low-idle or hybrid modulation.
// - the processor hold bit resets to one and, once cleared, lets the processor power up and send data.
// - the mute bit at position 3 ramps both channels softly down when set and back up when cleared.
// - bits 1-0 of the power register request deep sleep, sleep, high impedance or play.
// - the page wrap bit governs auto-increment only in books other than book zero.
// - with page wrap at zero an access past the page end continues at address 8 of the next page.
// - with page wrap at one an access past the page end wraps to address 0 of the same page.
// - bits 7-4 of the frame register hold the bit clocks per frame code for 32 to 512.
// - bits 3-0 of the frame register select automatic or a fixed sample rate mode.
package adcr_pkg;

    // register offsets
    localparam logic [7:0] ADCR_OFS_STAGE = 8'h02;
    localparam logic [7:0] ADCR_OFS_POWER = 8'h03;
    localparam logic [7:0] ADCR_OFS_PAGE = 8'h0F;
    localparam logic [7:0] ADCR_OFS_FRAME = 8'h28;
    localparam logic [7:0] ADCR_OFS_STATUS = 8'h40;

    // reset values
    localparam logic [7:0] ADCR_RST_STAGE = 8'h00;
    localparam logic [7:0] ADCR_RST_POWER = 8'h10;
    localparam logic [7:0] ADCR_RST_PAGE = 8'h00;
    localparam logic [7:0] ADCR_RST_FRAME = 8'h00;

    // field positions
    localparam int ADCR_FSW_LSB = 4;
    localparam int ADCR_PBTL_BIT = 2;
    localparam int ADCR_MOD_LSB = 0;
    localparam int ADCR_HOLD_BIT = 4;
    localparam int ADCR_MUTE_BIT = 3;
    localparam int ADCR_STATE_LSB = 0;
    localparam int ADCR_WRAP_BIT = 3;
    localparam int ADCR_RATIO_LSB = 4;
    localparam int ADCR_FS_LSB = 0;

    // page geometry for auto-increment
    localparam logic [7:0] ADCR_PAGE_LAST = 8'h7F;
    localparam logic [7:0] ADCR_PAGE_RESUME = 8'h08;
    localparam logic [7:0] ADCR_PAGE_FIRST = 8'h00;

    // soft ramp timing
    localparam int ADCR_RAMP_STEP_NS = 1000;
    localparam int ADCR_CLK_NS = 100;
    localparam int ADCR_RAMP_STEP_CYC = (ADCR_RAMP_STEP_NS + ADCR_CLK_NS - 1) / ADCR_CLK_NS;

    // switching rate codes
    localparam logic [2:0] ADCR_FSW_768 = 3'h0;
    localparam logic [2:0] ADCR_FSW_384 = 3'h1;
    localparam logic [2:0] ADCR_FSW_480 = 3'h3;
    localparam logic [2:0] ADCR_FSW_576 = 3'h4;

    // bit clock ratio codes
    localparam logic [3:0] ADCR_BCK_32 = 4'h3;
    localparam logic [3:0] ADCR_BCK_64 = 4'h5;
    localparam logic [3:0] ADCR_BCK_128 = 4'h7;
    localparam logic [3:0] ADCR_BCK_256 = 4'h9;
    localparam logic [3:0] ADCR_BCK_512 = 4'hB;

    // sample rate codes
    localparam logic [3:0] ADCR_FS_AUTO = 4'h0;
    localparam logic [3:0] ADCR_FS_32K = 4'h6;
    localparam logic [3:0] ADCR_FS_44K1 = 4'h8;
    localparam logic [3:0] ADCR_FS_48K = 4'h9;
    localparam logic [3:0] ADCR_FS_88K2 = 4'hA;
    localparam logic [3:0] ADCR_FS_96K = 4'hB;

    typedef enum logic [1:0] {
        ADCR_MOD_BD,
        ADCR_MOD_LOW_IDLE,
        ADCR_MOD_HYBRID,
        ADCR_MOD_RSVD
    } adcr_mod_t;

    typedef enum logic [1:0] {
        ADCR_PWR_DEEP_SLEEP,
        ADCR_PWR_SLEEP,
        ADCR_PWR_HIZ,
        ADCR_PWR_PLAY
    } adcr_pwr_t;

endpackage : adcr_pkg

// *** core/adcr_regs.sv ***
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ns
module adcr_regs #(
    parameter int VOL_W = 8,
    parameter int RAMP_STEP_CYC = adcr_pkg::ADCR_RAMP_STEP_CYC
) (
    input wire logic clk_sys, // 10 MHz system clock
    input wire logic rst_n, // asynchronous reset, active low
    input wire logic [7:0] reg_addr, // register address
    input wire logic [7:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [7:0] reg_rdata, // read data, cycle after strobe
    input wire logic [7:0] book_sel, // current book of the auto-increment access
    input wire logic [7:0] inc_addr, // address being auto-incremented
    input wire logic inc_req, // request next address
    output logic [7:0] inc_next, // next auto-increment address
    output logic inc_page_step, // next address lies on the following page
    output logic [2:0] switching_freq_select, // applied switching rate code
    output logic [9:0] switching_khz, // switching rate in kHz
    output logic parallel_bridge_select, // 1 paralleled bridge output
    output logic [1:0] modulation_scheme, // applied modulation
    output logic single_sided_low_idle, // low-idle modulation active
    output logic processor_hold, // processor held in reset
    output logic [1:0] power_state, // applied power state
    output logic [VOL_W-1:0] ramp_gain, // soft mute volume ramp
    output logic mute_done, // ramp fully down while muted
    output logic [3:0] bitclock_frame_ratio, // bit clocks per frame code
    output logic [3:0] sample_rate_select, // sample rate mode code
    output logic sample_rate_auto // automatic rate detection active
);

    // parameter limits, refused at elaboration; the step counter is 16 bits wide
    if (VOL_W < 2 || VOL_W > 16) begin : g_bad_vol
        $error("adcr_regs: VOL_W out of range");
    end
    if (RAMP_STEP_CYC < 1 || RAMP_STEP_CYC > 65536) begin : g_bad_step
        $error("adcr_regs: RAMP_STEP_CYC out of range");
    end

    localparam logic [VOL_W-1:0] VOL_FULL = {VOL_W{1'b1}};
    localparam logic [VOL_W-1:0] VOL_ONE = VOL_W'(1);

    ////////////////////////////////////////////////////////////////////////////
    logic [7:0] output_stage_config;
    logic [7:0] power_state_and_mute;
    logic [7:0] page_increment_config;
    logic [7:0] audio_frame_rate_config;
    logic [15:0] ramp_cnt;
    logic [2:0] fsw_raw;
    logic [1:0] mod_raw;
    logic [3:0] ratio_raw;
    logic [3:0] fs_raw;

    // register writes, reserved bits kept as written
    // plain storage
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            output_stage_config <= adcr_pkg::ADCR_RST_STAGE;
            power_state_and_mute <= adcr_pkg::ADCR_RST_POWER;
            page_increment_config <= adcr_pkg::ADCR_RST_PAGE;
            audio_frame_rate_config <= adcr_pkg::ADCR_RST_FRAME;
        end else if (reg_wr) begin
            unique case (reg_addr)
                adcr_pkg::ADCR_OFS_STAGE: output_stage_config <= reg_wdata;
                adcr_pkg::ADCR_OFS_POWER: power_state_and_mute <= reg_wdata;
                adcr_pkg::ADCR_OFS_PAGE: page_increment_config <= reg_wdata;
                adcr_pkg::ADCR_OFS_FRAME: audio_frame_rate_config <= reg_wdata;
                default: ;
            endcase
        end
    end

    // read data, unmapped addresses read zero
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                adcr_pkg::ADCR_OFS_STAGE: reg_rdata <= output_stage_config;
                adcr_pkg::ADCR_OFS_POWER: reg_rdata <= power_state_and_mute;
                adcr_pkg::ADCR_OFS_PAGE: reg_rdata <= page_increment_config;
                adcr_pkg::ADCR_OFS_FRAME: reg_rdata <= audio_frame_rate_config;
                adcr_pkg::ADCR_OFS_STATUS: reg_rdata <= {mute_done, processor_hold, power_state,
                    sample_rate_auto, single_sided_low_idle, parallel_bridge_select, |ramp_gain};
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // raw field slices
    assign fsw_raw = output_stage_config[adcr_pkg::ADCR_FSW_LSB +: 3];
    assign mod_raw = output_stage_config[adcr_pkg::ADCR_MOD_LSB +: 2];
    assign ratio_raw = audio_frame_rate_config[adcr_pkg::ADCR_RATIO_LSB +: 4];
    assign fs_raw = audio_frame_rate_config[adcr_pkg::ADCR_FS_LSB +: 4];

    // applied settings; reserved codes hold the last legal setting
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            switching_freq_select <= adcr_pkg::ADCR_FSW_768;
            switching_khz <= 10'd768;
            modulation_scheme <= adcr_pkg::ADCR_MOD_BD;
            bitclock_frame_ratio <= 4'h0;
            sample_rate_select <= adcr_pkg::ADCR_FS_AUTO;
        end else begin
            unique case (fsw_raw)
                adcr_pkg::ADCR_FSW_768: begin
                    switching_freq_select <= fsw_raw;
                    switching_khz <= 10'd768;
                end
                adcr_pkg::ADCR_FSW_384: begin
                    switching_freq_select <= fsw_raw;
                    switching_khz <= 10'd384;
                end
                adcr_pkg::ADCR_FSW_480: begin
                    switching_freq_select <= fsw_raw;
                    switching_khz <= 10'd480;
                end
                adcr_pkg::ADCR_FSW_576: begin
                    switching_freq_select <= fsw_raw;
                    switching_khz <= 10'd576;
                end
                default: ;
            endcase
            if (mod_raw != adcr_pkg::ADCR_MOD_RSVD) begin
                modulation_scheme <= mod_raw;
            end
            unique case (ratio_raw)
                adcr_pkg::ADCR_BCK_32, adcr_pkg::ADCR_BCK_64, adcr_pkg::ADCR_BCK_128,
                adcr_pkg::ADCR_BCK_256, adcr_pkg::ADCR_BCK_512: bitclock_frame_ratio <= ratio_raw;
                default: ;
            endcase
            unique case (fs_raw)
                adcr_pkg::ADCR_FS_AUTO, adcr_pkg::ADCR_FS_32K, adcr_pkg::ADCR_FS_44K1,
                adcr_pkg::ADCR_FS_48K, adcr_pkg::ADCR_FS_88K2,
                adcr_pkg::ADCR_FS_96K: sample_rate_select <= fs_raw;
                default: ;
            endcase
        end
    end

    assign single_sided_low_idle = (modulation_scheme == adcr_pkg::ADCR_MOD_LOW_IDLE);
    assign sample_rate_auto = (sample_rate_select == adcr_pkg::ADCR_FS_AUTO);

    assign parallel_bridge_select = output_stage_config[adcr_pkg::ADCR_PBTL_BIT];
    assign processor_hold = power_state_and_mute[adcr_pkg::ADCR_HOLD_BIT];
    assign power_state = power_state_and_mute[adcr_pkg::ADCR_STATE_LSB +: 2];

    ////////////////////////////////////////////////////////////////////////////
    // soft mute ramp, one step every RAMP_STEP_CYC cycles
    // soft volume ramp
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ramp_cnt <= 16'h0000;
            ramp_gain <= VOL_FULL;
        end else if (ramp_cnt != 16'h0000) begin
            ramp_cnt <= ramp_cnt - 16'h0001;
        end else begin
            ramp_cnt <= 16'(RAMP_STEP_CYC - 1);
            if (power_state_and_mute[adcr_pkg::ADCR_MUTE_BIT]) begin
                if (ramp_gain != '0) ramp_gain <= ramp_gain - VOL_ONE;
            end else if (ramp_gain != VOL_FULL) begin
                ramp_gain <= ramp_gain + VOL_ONE;
            end
        end
    end

    assign mute_done = power_state_and_mute[adcr_pkg::ADCR_MUTE_BIT] && (ramp_gain == '0);

    ////////////////////////////////////////////////////////////////////////////
    // auto-increment address step
    always_comb begin
        inc_next = inc_addr + 8'h01;
        inc_page_step = 1'b0;
        if (inc_req && book_sel != 8'h00 && inc_addr == adcr_pkg::ADCR_PAGE_LAST) begin
            if (page_increment_config[adcr_pkg::ADCR_WRAP_BIT]) begin
                inc_next = adcr_pkg::ADCR_PAGE_FIRST;
            end else begin
                inc_next = adcr_pkg::ADCR_PAGE_RESUME;
                inc_page_step = 1'b1;
            end
        end
    end

endmodule : adcr_regs

// *** tb/adcr_regs_monitor.sv ***
`timescale 1ns/1ns
module adcr_regs_monitor #(
    parameter int VOL_W = 8
) (
    input wire logic clk_sys, // system clock
    input wire logic rst_n, // reset, active low
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    input wire logic inc_req, // page end qualifier
    input wire logic inc_page_step, // next page flag
    input wire logic [7:0] reg_addr, // register address
    input wire logic [7:0] reg_wdata, // write data
    input wire logic [7:0] reg_rdata, // read data
    input wire logic [7:0] book_sel, // current book
    input wire logic [7:0] inc_addr, // address being incremented
    input wire logic [7:0] inc_next, // next address
    input wire logic parallel_bridge_select, // paralleled bridge
    input wire logic single_sided_low_idle, // low-idle flag
    input wire logic processor_hold, // processor held
    input wire logic mute_done, // ramp down complete
    input wire logic sample_rate_auto, // automatic rate flag
    input wire logic [2:0] switching_freq_select, // rate code
    input wire logic [9:0] switching_khz, // rate in kHz
    input wire logic [1:0] modulation_scheme, // applied modulation
    input wire logic [1:0] power_state, // power state
    input wire logic [VOL_W-1:0] ramp_gain, // volume ramp
    input wire logic [3:0] bitclock_frame_ratio, // ratio code
    input wire logic [3:0] sample_rate_select // rate mode code
);
    logic wrap; // shadow of the page wrap bit
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // follows page wrap bit writes
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) wrap <= 1'b0;
        else if (reg_wr && reg_addr == 8'h0F) wrap <= reg_wdata[3];
    end
    sequence s_stage_wr; reg_wr && reg_addr == 8'h02; endsequence
    sequence s_power_wr; reg_wr && reg_addr == 8'h03; endsequence
    ////////////////////////////////////////////////////////////////
    a_read_data_idle: assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("read data not idle");
    a_bridge_direct: assert property (s_stage_wr |=> parallel_bridge_select == $past(reg_wdata[2]))
        else $error("bridge select wrong");
    a_hold_state_direct: assert property (s_power_wr |=>
        processor_hold == $past(reg_wdata[4]) && power_state == $past(reg_wdata[1:0])) else $error("power bits wrong");
    a_rate_applied: assert property (s_stage_wr ##0 reg_wdata[6:4] == 3'h3 |->
        ##2 switching_freq_select == 3'h3 && switching_khz == 10'h1E0) else $error("rate 480 not applied");
    a_rate_khz_map: assert property (switching_khz == (switching_freq_select == 3'h1 ? 10'h180 :
        switching_freq_select == 3'h3 ? 10'h1E0 : switching_freq_select == 3'h4 ? 10'h240 : 10'h300))
        else $error("rate kHz wrong");
    a_applied_legal: assert property (switching_freq_select inside {3'h0, 3'h1, 3'h3, 3'h4} &&
        modulation_scheme != 2'h3 && bitclock_frame_ratio inside {4'h0, 4'h3, 4'h5, 4'h7, 4'h9, 4'hB} &&
        sample_rate_select inside {4'h0, 4'h6, 4'h8, 4'h9, 4'hA, 4'hB}) else $error("reserved code applied");
    a_mode_flags: assert property (single_sided_low_idle == (modulation_scheme == 2'h1) &&
        sample_rate_auto == (sample_rate_select == 4'h0)) else $error("mode flag wrong");
    a_page_end_wrap: assert property (inc_req && book_sel != 8'h00 && inc_addr == 8'h7F |->
        inc_next == (wrap ? 8'h00 : 8'h08) && inc_page_step == !wrap) else $error("page end wrong");
    a_book_zero_plain: assert property (book_sel == 8'h00 |->
        inc_next == inc_addr + 8'h01 && !inc_page_step) else $error("book zero increment wrong");
    a_mute_done_zero: assert property (mute_done |-> ramp_gain == '0 ##1 ramp_gain == '0)
        else $error("mute done early");
    a_ramp_soft: assert property (ramp_gain != $past(ramp_gain) |->
        ramp_gain == $past(ramp_gain) + 1'b1 || ramp_gain == $past(ramp_gain) - 1'b1) else $error("ramp jumped");
endmodule : adcr_regs_monitor
bind adcr_regs adcr_regs_monitor #(.VOL_W(VOL_W)) i_mon (.clk_sys, .rst_n, .reg_wr, .reg_rd, .inc_req,
    .inc_page_step, .reg_addr, .reg_wdata, .reg_rdata, .book_sel, .inc_addr, .inc_next, .parallel_bridge_select,
    .single_sided_low_idle, .processor_hold, .mute_done, .sample_rate_auto, .switching_freq_select,
    .switching_khz, .modulation_scheme, .power_state, .ramp_gain, .bitclock_frame_ratio, .sample_rate_select);

// *** tb/adcr_host_model.sv ***
`timescale 1ns/1ns
module adcr_host_model (
    input wire logic clk_sys, // system clock
    input wire logic [7:0] reg_rdata, // read data
    output logic [7:0] reg_addr, // address
    output logic [7:0] reg_wdata, // write data
    output logic reg_wr, // write strobe
    output logic reg_rd // read strobe
);
    // idle bus at time zero
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // one-cycle write, lines inverted once released
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~v;
    endtask : wr
    // one-cycle read, data taken in the following cycle
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(negedge clk_sys);
        q = reg_rdata;
    endtask : rd
endmodule : adcr_host_model

// *** tb/test_amp_device_control_regs.sv ***
`timescale 1ns/1ns
module test_amp_device_control_regs;
    logic clk_sys, rst_n, reg_wr, reg_rd, inc_req, inc_page_step, parallel_bridge_select;
    logic single_sided_low_idle, processor_hold, mute_done, sample_rate_auto;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, book_sel, inc_addr, inc_next, ramp_gain, d;
    logic [9:0] switching_khz;
    logic [2:0] switching_freq_select;
    logic [1:0] modulation_scheme, power_state;
    logic [3:0] bitclock_frame_ratio, sample_rate_select;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    adcr_regs #(.RAMP_STEP_CYC(1)) i_dut (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .book_sel, .inc_addr, .inc_req, .inc_next, .inc_page_step, .switching_freq_select, .switching_khz,
        .parallel_bridge_select, .modulation_scheme, .single_sided_low_idle, .processor_hold, .power_state,
        .ramp_gain, .mute_done, .bitclock_frame_ratio, .sample_rate_select, .sample_rate_auto);
    adcr_host_model i_host (.clk_sys, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        i_host.rd(a, d);
        check(d, exp);
    endtask : rdc
    ////////////////////////////////////////////////////////////////
    // reset values
    task automatic t_reset;
        rdc(8'h02, 8'h00);
        rdc(8'h03, 8'h10);
        rdc(8'h0F, 8'h00);
        rdc(8'h28, 8'h00);
        rdc(8'h40, 8'h49);
        check(processor_hold, 1'b1);
        check(switching_khz, 10'h300);
        check(ramp_gain, 8'hFF);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_stage;
        logic [2:0] fc [4] = '{3'h0, 3'h1, 3'h3, 3'h4};
        logic [9:0] kz [4] = '{10'h300, 10'h180, 10'h1E0, 10'h240};
        for (int i = 0; i < 4; i++) begin
            i_host.wr(8'h02, {1'b0, fc[i], 1'b0, i[0], (i < 3) ? i[1:0] : 2'h0});
            rdc(8'h02, {1'b0, fc[i], 1'b0, i[0], (i < 3) ? i[1:0] : 2'h0});
            check(switching_khz, kz[i]);
            check(parallel_bridge_select, i[0]);
            check(modulation_scheme, (i < 3) ? i[1:0] : 2'h0);
            check(single_sided_low_idle, i == 1);
        end
        i_host.wr(8'h02, 8'hAF);
        rdc(8'h02, 8'hAF);
        check(switching_freq_select, 3'h4);
        check(modulation_scheme, 2'h0);
        $display("t_stage done");
    endtask : t_stage
    task automatic t_power;
        for (int s = 0; s < 4; s++) begin
            // audio clocks stable before hold release
            i_host.wr(8'h03, {6'h00, s[1:0]});
            rdc(8'h03, {6'h00, s[1:0]});
            check(power_state, s[1:0]);
            check(processor_hold, 1'b0);
        end
        i_host.wr(8'h03, 8'hF3);
        rdc(8'h03, 8'hF3);
        check(processor_hold, 1'b1);
        $display("t_power done");
    endtask : t_power
    task automatic t_mute;
        i_host.wr(8'h03, 8'h0B);
        @(negedge clk_sys);
        check(mute_done, 1'b0);
        for (int n = 0; n < 400 && mute_done !== 1'b1; n++) @(negedge clk_sys);
        check(ramp_gain, 8'h00);
        rdc(8'h40, 8'hBA);
        i_host.wr(8'h03, 8'h03);
        for (int n = 0; n < 400 && ramp_gain !== 8'hFF; n++) @(negedge clk_sys);
        check(ramp_gain, 8'hFF);
        $display("t_mute done");
    endtask : t_mute
    task automatic t_wrap;
        @(posedge clk_sys);
        book_sel <= 8'h01;
        inc_addr <= 8'h7F;
        inc_req <= 1'b1;
        @(negedge clk_sys);
        check({inc_page_step, inc_next}, 9'h108);
        i_host.wr(8'h0F, 8'h08);
        @(negedge clk_sys);
        check({inc_page_step, inc_next}, 9'h000);
        @(posedge clk_sys);
        book_sel <= 8'h00;
        @(negedge clk_sys);
        check({inc_page_step, inc_next}, 9'h080);
        $display("t_wrap done");
    endtask : t_wrap
    task automatic t_frame;
        logic [3:0] rc [5] = '{4'h3, 4'h5, 4'h7, 4'h9, 4'hB};
        logic [3:0] fs [6] = '{4'h0, 4'h6, 4'h8, 4'h9, 4'hA, 4'hB};
        for (int i = 0; i < 6; i++) begin
            i_host.wr(8'h28, {rc[i%5], fs[i]});
            rdc(8'h28, {rc[i%5], fs[i]});
            check({bitclock_frame_ratio, sample_rate_select}, {rc[i%5], fs[i]});
            check(sample_rate_auto, i == 0);
        end
        i_host.wr(8'h28, 8'h21);
        rdc(8'h28, 8'h21);
        check({bitclock_frame_ratio, sample_rate_select}, 8'h3B);
        i_host.wr(8'h50, 8'h55);
        rdc(8'h50, 8'h00);
        $display("t_frame done");
    endtask : t_frame
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : complete_run
    ////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            complete_run;
        end
    end
    initial begin
        rst_n = 1'b0;
        book_sel = 8'h00;
        inc_addr = 8'h00;
        inc_req = 1'b0;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset;
        t_stage;
        t_power;
        t_mute;
        t_wrap;
        t_frame;
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset;
        complete_run;
    end
endmodule : test_amp_device_control_regs
